/* bench/frqp_src_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Frequency front end and blocking matrix
// ----------------------------------------------------------------------
module frqp_src_model #(
  parameter int PC_CLKS = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Requests from the bench
  input wire logic [15:0] freq_set,
  input wire logic blk_set,
  // Device side
  output logic [15:0] freq_in,
  output logic freq_valid,
  output logic block_pin
);
  int cnt;

  // A new sample only once per program-cycle length, as slow as a real tracker.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      freq_in <= 16'h0000;
      freq_valid <= 1'b0;
      block_pin <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == PC_CLKS - 1) ? 0 : cnt + 1;
      freq_valid <= (cnt == 0);
      if (cnt == 0)
      begin
        freq_in <= freq_set;
      end
      block_pin <= blk_set;
    end
  end
endmodule : frqp_src_model

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); end end

module tb_top;
  localparam int MSC = 4;
  localparam int PC = 5 * MSC;
  logic sys_clk;
  logic rst;
  logic [15:0] freq_set, freq_in, thr, f, dlt, evt_fault_freq, last_fault;
  logic blk_set, freq_valid, block_pin, block_ind, evt_valid, ov, up;
  logic [7:0] reg_addr, stage_start, stage_trip, stage_blocked;
  logic [31:0] reg_wdata, reg_rdata, rv, seed;
  logic reg_wr, reg_rd;
  logic [5:0] evt_code;
  logic [2:0] sidx;
  logic [5:0] evq[$];
  int fail_count, samples_checked, n;

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  frqp_src_model #(.PC_CLKS(PC)) i_frqp_src_model (
    .sys_clk(sys_clk), .rst(rst), .freq_set(freq_set), .blk_set(blk_set),
    .freq_in(freq_in), .freq_valid(freq_valid), .block_pin(block_pin)
  );

  frqp_top #(.MS_CYCLES(MSC)) i_frqp_top (
    .sys_clk(sys_clk), .rst(rst), .freq_in(freq_in), .freq_valid(freq_valid),
    .block_pin(block_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stage_start(stage_start),
    .stage_trip(stage_trip), .stage_blocked(stage_blocked), .block_ind(block_ind),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(), .evt_pre_freq(),
    .evt_fault_freq(evt_fault_freq)
  );

  always @(posedge sys_clk)
    if (evt_valid === 1'b1)
    begin
      evq.push_back(evt_code);
      last_fault = evt_fault_freq;
    end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic logic exp_pick(input logic [15:0] t, input logic [15:0] v, input logic o);
    return o ? (v > t) : (v < t);
  endfunction : exp_pick

  task tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task chk_rd(input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    `CHK(rv, e)
  endtask : chk_rd

  task stim(input logic [15:0] v, input logic b, input int k);
    @(posedge sys_clk);
    freq_set <= v;
    blk_set <= b;
    tick(k * PC);
  endtask : stim

  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    freq_set = 16'h1388;
    blk_set = 1'b0;
    seed = 32'h4b3607c1;
    fail_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    chk_rd(frqp_pkg::REG_CTRL, frqp_pkg::CTRL_RST);
    chk_rd(8'h40, {16'h0000, frqp_pkg::THR_OVER_RST});
    chk_rd(8'h50, {16'h0000, frqp_pkg::THR_UNDER_RST});
    chk_rd(8'h60, {13'h0000, frqp_pkg::DLY_RST});
    chk_rd(8'hFC, 32'h00000000);
    for (int m = 1; m <= 5; m++)
    begin
      wr(frqp_pkg::REG_CTRL, 32'h00000060 | m);
      rd(frqp_pkg::REG_STATUS, rv);
      `CHK(rv[18:16], 3'(m))
    end
    wr(frqp_pkg::REG_CTRL, frqp_pkg::CTRL_RST);
    // Stage 0 over, two program cycles of delay; equal to threshold must not pick up.
    wr(8'h60, 32'h00000002);
    wr(8'h40, 32'h000113EC);
    stim(16'h13EC, 1'b0, 3);
    `CHK(stage_start[0], 1'b0)
    chk_rd(frqp_pkg::REG_RATIO, 32'h000003E8);
    chk_rd(frqp_pkg::REG_EXPECT, 32'h00000002);
    evq.delete();
    stim(16'h1452, 1'b0, 0);
    n = 0;
    while (stage_start[0] !== 1'b1 && n < 3 * PC)
    begin
      tick(1);
      n++;
    end
    `CHK(stage_start[0], 1'b1)
    n = 0;
    while (stage_trip[0] !== 1'b1 && n < 4 * PC)
    begin
      tick(1);
      n++;
    end
    `CHK(n, 2 * PC)
    `CHK(stage_start[1], 1'b0)
    chk_rd(frqp_pkg::REG_RATIO, 32'h000003FC);
    `CHK(evq.size(), 2)
    `CHK(evq[0], 6'h01)
    `CHK(evq[1], 6'h03)
    `CHK(last_fault, 16'h1452)
    rd(frqp_pkg::REG_STATUS, rv);
    `CHK(rv[1:0], frqp_pkg::COND_TRIP)
    rd(frqp_pkg::REG_REC_SEL, rv);
    `CHK(rv[7:4], 4'h2)
    wr(frqp_pkg::REG_REC_SEL, 32'h00000000);
    rd(frqp_pkg::REG_REC_EVT, rv);
    `CHK(rv[8:0], 9'h001)
    chk_rd(frqp_pkg::REG_COUNTS, 32'h00000101);
    wr(frqp_pkg::REG_CNT_CLR, 32'h00000001);
    chk_rd(frqp_pkg::REG_COUNTS, 32'h00000000);
    // Inside the return band the stage must hold; well below it must drop.
    stim(16'h13EB, 1'b0, 3);
    `CHK(stage_trip[0], 1'b1)
    wr(frqp_pkg::REG_CTRL, 32'h00000021);
    evq.delete();
    stim(16'h13E2, 1'b0, 3);
    `CHK(stage_trip[0], 1'b0)
    `CHK(evq.size(), 0)
    wr(frqp_pkg::REG_CTRL, 32'h00000041);
    stim(16'h1452, 1'b0, 4);
    `CHK(evq.size(), 0)
    stim(16'h1388, 1'b0, 2);
    `CHK(evq.size(), 2)
    `CHK(evq[0], 6'h00)
    `CHK(evq[1], 6'h02)
    wr(frqp_pkg::REG_CTRL, frqp_pkg::CTRL_RST);
    // Stage 4 under: blocked at pick-up, then blocked after start.
    wr(8'h50, 32'h00011324);
    stim(16'h1388, 1'b1, 1);
    stim(16'h12C0, 1'b1, 3);
    `CHK(stage_blocked[4], 1'b1)
    `CHK(stage_start[4], 1'b0)
    `CHK(block_ind, 1'b1)
    rd(frqp_pkg::REG_STATUS, rv);
    `CHK(rv[9:8], frqp_pkg::COND_BLOCKED)
    stim(16'h1388, 1'b0, 2);
    stim(16'h12C0, 1'b0, 3);
    `CHK(stage_start[4], 1'b1)
    stim(16'h12C0, 1'b1, 2);
    `CHK(stage_start[4], 1'b0)
    `CHK(stage_trip[4], 1'b0)
    stim(16'h1388, 1'b0, 3);
    wr(frqp_pkg::REG_CTRL, 32'h00000079);
    stim(16'h12C0, 1'b0, 3);
    `CHK(stage_blocked[4], 1'b1)
    `CHK(stage_start[4], 1'b0)
    wr(frqp_pkg::REG_CTRL, frqp_pkg::CTRL_RST);
    stim(16'h1388, 1'b0, 2);
    // Random thresholds and samples on one over and one under stage.
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      ov = seed[0];
      up = seed[1];
      thr = (ov ? 16'h1388 : 16'h12C0) + 16'(seed[15:8]);
      dlt = 16'(seed[21:16]);
      f = (ov == up) ? thr + 16'h0003 + dlt : thr - 16'h0003 - dlt;
      sidx = ov ? 3'h0 : 3'h5;
      wr(ov ? 8'h40 : 8'h54, 32'h00010000 | 32'(thr));
      stim(f, 1'b0, 3);
      `CHK(stage_start[sidx] | stage_trip[sidx], exp_pick(thr, f, ov))
    end
    test_done();
  end
endmodule : tb_top

`default_nettype wire

/* design/frqp_top.sv */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module frqp_top #(
  parameter int MS_CYCLES = frqp_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Frequency source and blocking matrix
  input wire logic [15:0] freq_in,
  input wire logic freq_valid,
  input wire logic block_pin,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Stage outputs
  output logic [7:0] stage_start,
  output logic [7:0] stage_trip,
  output logic [7:0] stage_blocked,
  output logic block_ind,
  // Event stream
  output logic evt_valid,
  output logic [5:0] evt_code,
  output logic [31:0] evt_stamp,
  output logic [15:0] evt_pre_freq,
  output logic [15:0] evt_fault_freq
);

  initial
  begin
    if (MS_CYCLES < 2)
    begin
      $error("MS_CYCLES must be at least 2");
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ms_cnt;
    logic [2:0] pc_cnt;
    logic pc;
    logic [31:0] stamp;
    logic [2:0] sync;
    logic blk_lvl;
    logic blk_q;
    logic [15:0] freq_q;
    logic [3:0][15:0] hist;
    logic [31:0] ctrl;
    logic [7:0][15:0] thr;
    logic [7:0][7:0] sgen;
    logic [7:0][18:0] dly;
    logic [7:0][1:0] frc;
    logic [7:0] picked;
    logic [7:0] started;
    logic [7:0] tripped;
    logic [7:0] blked;
    logic [7:0][18:0] cnt;
    logic [7:0] o_start;
    logic [7:0] o_trip;
    logic [7:0] o_blk;
    logic [63:0] pend;
    logic [31:0] pc_stamp;
    logic [15:0] pc_pre;
    logic [15:0] pc_fault;
    logic [7:0][23:0] cnts;
    logic [11:0][72:0] rec;
    logic [3:0] rec_wp;
    logic [3:0] rec_sel;
    logic evt_v;
    logic [5:0] evt_code;
    logic block_ind;
    logic [31:0] rdata;
  } frqp_state_s;

  frqp_state_s q;
  frqp_state_s d;

  logic blk_now;
  logic [2:0] mode;
  logic [2:0] sg;
  logic [2:0] sel;
  logic [7:0] en;
  logic [7:0] pick_new;
  logic [25:0] ratio;
  logic [5:0] pick_code;
  logic pick_any;
  logic [7:0] raw_s;
  logic [7:0] raw_t;
  logic [7:0] raw_b;
  logic [31:0] status;

  assign mode = q.ctrl[frqp_pkg::CTRL_MODE_LSB +: 3];
  assign sg = q.ctrl[frqp_pkg::CTRL_SG_LSB +: 3];
  assign sel = q.ctrl[frqp_pkg::CTRL_SEL_LSB +: 3];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    d = q;
    pick_new = '0;
    en = '0;
    raw_s = '0;
    raw_t = '0;
    raw_b = '0;
    pick_code = '0;
    pick_any = 1'b0;
    status = '0;
    ratio = '0;
    // One-millisecond stamp base; the program cycle is one delay step long.
    d.pc = 1'b0;
    d.ms_cnt = q.ms_cnt + 32'h00000001;
    if (q.ms_cnt == 32'(MS_CYCLES - 1))
    begin
      d.ms_cnt = '0;
      d.stamp = q.stamp + 32'h00000001;
      d.pc_cnt = q.pc_cnt + 3'h1;
      if (q.pc_cnt == 3'(frqp_pkg::PC_MS - 1))
      begin
        d.pc_cnt = '0;
        d.pc = 1'b1;
      end
    end
    // Three-stage synchroniser; a change counts once the last two agree.
    d.sync = {q.sync[1:0], block_pin};
    if (q.sync[1] == q.sync[2])
    begin
      d.blk_lvl = q.sync[2];
    end
    if (freq_valid)
    begin
      d.freq_q = freq_in;
    end
    // Blocking source: matrix, software switch under forcing, or node mode.
    blk_now = q.blk_lvl | (q.ctrl[frqp_pkg::CTRL_FORCE] & q.ctrl[frqp_pkg::CTRL_SWBLK])
      | (mode == frqp_pkg::MODE_BLOCKED) | (mode == frqp_pkg::MODE_TESTBLK);
    for (int i = 0; i < frqp_pkg::NSTG; i++)
    begin
      en[i] = q.sgen[i][sg] & (mode != frqp_pkg::MODE_OFF);
      if (i < frqp_pkg::NOVER)
      begin
        pick_new[i] = q.picked[i] ? (q.freq_q > q.thr[i] - frqp_pkg::HYS)
          : (q.freq_q > q.thr[i]);
      end
      else
      begin
        pick_new[i] = q.picked[i] ? (q.freq_q < q.thr[i] + frqp_pkg::HYS)
          : (q.freq_q < q.thr[i]);
      end
      pick_new[i] = pick_new[i] & en[i];
    end
    if (q.pc)
    begin
      d.blk_q = blk_now;
      d.hist = {q.hist[2:0], q.freq_q};
      d.pc_stamp = q.stamp;
      d.pc_pre = q.hist[frqp_pkg::PRE_DEPTH - 1];
      d.pc_fault = q.freq_q;
      for (int i = 0; i < frqp_pkg::NSTG; i++)
      begin
        d.picked[i] = pick_new[i];
        if (!pick_new[i])
        begin
          d.started[i] = 1'b0;
          d.tripped[i] = 1'b0;
          d.blked[i] = 1'b0;
          d.cnt[i] = '0;
        end
        else if (!q.picked[i])
        begin
          d.blked[i] = blk_now;
          d.started[i] = !blk_now;
          d.tripped[i] = !blk_now && (q.dly[i] == '0);
          d.cnt[i] = '0;
        end
        else if (q.started[i] && blk_now)
        begin
          d.started[i] = 1'b0;
          d.tripped[i] = 1'b0;
          d.blked[i] = 1'b1;
          d.cnt[i] = '0;
        end
        else if (q.started[i] && !q.tripped[i])
        begin
          d.cnt[i] = q.cnt[i] + 19'h00001;
          d.tripped[i] = (q.cnt[i] + 19'h00001 >= q.dly[i]);
        end
        raw_s[i] = d.started[i];
        raw_t[i] = d.tripped[i];
        raw_b[i] = d.blked[i];
        if (q.ctrl[frqp_pkg::CTRL_FORCE] && q.frc[i] != frqp_pkg::COND_NORMAL)
        begin
          raw_s[i] = (q.frc[i] == frqp_pkg::COND_START) | (q.frc[i] == frqp_pkg::COND_TRIP);
          raw_t[i] = (q.frc[i] == frqp_pkg::COND_TRIP);
          raw_b[i] = (q.frc[i] == frqp_pkg::COND_BLOCKED);
        end
        d.o_start[i] = raw_s[i];
        d.o_trip[i] = raw_t[i];
        d.o_blk[i] = raw_b[i];
      end
      d.block_ind = |raw_b;
    end
    // Counters: a clear in the same cycle as an increment keeps the increment.
    if (reg_wr && reg_addr == frqp_pkg::REG_CNT_CLR && reg_wdata[0])
    begin
      d.cnts = '0;
    end
    for (int i = 0; i < frqp_pkg::NSTG; i++)
    begin
      if (q.pc)
      begin
        d.cnts[i][7:0] = d.cnts[i][7:0] + 8'(raw_s[i] & ~q.o_start[i]);
        d.cnts[i][15:8] = d.cnts[i][15:8] + 8'(raw_t[i] & ~q.o_trip[i]);
        d.cnts[i][23:16] = d.cnts[i][23:16] + 8'(raw_b[i] & ~q.o_blk[i]);
      end
    end
    // Event emitter: one pending edge per clock, lowest code first.
    for (int k = 63; k >= 0; k--)
    begin
      if (q.pend[k])
      begin
        pick_any = 1'b1;
        pick_code = 6'(k);
      end
    end
    d.evt_v = 1'b0;
    d.pend = q.pend;
    if (pick_any)
    begin
      d.pend[pick_code] = 1'b0;
      d.evt_code = pick_code;
      d.evt_v = q.ctrl[frqp_pkg::CTRL_EVSEL_LSB + (pick_code[0] ? 0 : 1)];
      if (pick_code[0])
      begin
        d.rec[q.rec_wp] = {q.pc_stamp, pick_code, q.pc_pre, q.pc_fault, sg};
        d.rec_wp = (q.rec_wp == 4'(frqp_pkg::REC_DEPTH - 1)) ? 4'h0 : q.rec_wp + 4'h1;
      end
    end
    // New edges are set after the emitter clear so the set always wins.
    if (q.pc)
    begin
      for (int i = 0; i < frqp_pkg::NSTG; i++)
      begin
        if (raw_s[i] != q.o_start[i])
        begin
          d.pend[{3'(i), frqp_pkg::KIND_START, raw_s[i]}] = 1'b1;
        end
        if (raw_t[i] != q.o_trip[i])
        begin
          d.pend[{3'(i), frqp_pkg::KIND_TRIP, raw_t[i]}] = 1'b1;
        end
        if (raw_b[i] != q.o_blk[i])
        begin
          d.pend[{3'(i), frqp_pkg::KIND_BLOCKED, raw_b[i]}] = 1'b1;
        end
      end
    end
    // Register writes.
    if (reg_wr)
    begin
      if (reg_addr == frqp_pkg::REG_CTRL)
      begin
        d.ctrl = {19'h00000, reg_wdata[12:0]};
      end
      else if (reg_addr == frqp_pkg::REG_REC_SEL)
      begin
        d.rec_sel = reg_wdata[3:0];
      end
      else if (reg_addr[7:5] == frqp_pkg::REG_THR_PAGE)
      begin
        d.thr[reg_addr[4:2]] = reg_wdata[15:0];
        d.sgen[reg_addr[4:2]] = reg_wdata[frqp_pkg::THR_SGEN_LSB +: 8];
      end
      else if (reg_addr[7:5] == frqp_pkg::REG_DLY_PAGE)
      begin
        d.dly[reg_addr[4:2]] = (reg_wdata[18:0] > frqp_pkg::DLY_MAX) ? frqp_pkg::DLY_MAX
          : reg_wdata[18:0];
        d.frc[reg_addr[4:2]] = reg_wdata[frqp_pkg::DLY_FORCE_LSB +: 2];
      end
    end
    // Condition and behaviour fields.
    for (int i = 0; i < frqp_pkg::NSTG; i++)
    begin
      status[2*i +: 2] = q.o_trip[i] ? frqp_pkg::COND_TRIP
        : q.o_start[i] ? frqp_pkg::COND_START
        : q.o_blk[i] ? frqp_pkg::COND_BLOCKED : frqp_pkg::COND_NORMAL;
    end
    status[18:16] = mode;
    // Ratio in thousandths; a zero threshold reads as zero instead of dividing.
    if (q.thr[sel] != '0)
    begin
      ratio = ({10'h000, q.freq_q} * frqp_pkg::RATIO_SCALE) / {10'h000, q.thr[sel]};
    end
    d.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        frqp_pkg::REG_CTRL: d.rdata = q.ctrl;
        frqp_pkg::REG_STATUS: d.rdata = status;
        frqp_pkg::REG_RATIO: d.rdata = {6'h00, ratio};
        frqp_pkg::REG_REMAIN: d.rdata = 32'(signed'({1'b0, q.dly[sel]} - {1'b0, q.cnt[sel]}));
        frqp_pkg::REG_EXPECT: d.rdata = {13'h0000, q.dly[sel]};
        frqp_pkg::REG_COUNTS: d.rdata = {8'h00, q.cnts[sel]};
        frqp_pkg::REG_REC_SEL: d.rdata = {24'h000000, q.rec_wp, q.rec_sel};
        frqp_pkg::REG_REC_TIME: d.rdata = q.rec[q.rec_sel][72:41];
        frqp_pkg::REG_REC_EVT:
        begin
          d.rdata = {23'h000000, q.rec[q.rec_sel][2:0], q.rec[q.rec_sel][40:35]};
        end
        frqp_pkg::REG_REC_FREQ: d.rdata = q.rec[q.rec_sel][34:3];
        default:
        begin
          if (reg_addr[7:5] == frqp_pkg::REG_THR_PAGE)
          begin
            d.rdata = {8'h00, q.sgen[reg_addr[4:2]], q.thr[reg_addr[4:2]]};
          end
          else if (reg_addr[7:5] == frqp_pkg::REG_DLY_PAGE)
          begin
            d.rdata = {11'h000, q.frc[reg_addr[4:2]], q.dly[reg_addr[4:2]]};
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.ctrl <= frqp_pkg::CTRL_RST;
      for (int i = 0; i < frqp_pkg::NSTG; i++)
      begin
        q.thr[i] <= (i < frqp_pkg::NOVER) ? frqp_pkg::THR_OVER_RST : frqp_pkg::THR_UNDER_RST;
        q.dly[i] <= frqp_pkg::DLY_RST;
      end
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign stage_start = q.o_start;
  assign stage_trip = q.o_trip;
  assign stage_blocked = q.o_blk;
  assign block_ind = q.block_ind;
  assign evt_valid = q.evt_v;
  assign evt_code = q.evt_code;
  assign evt_stamp = q.pc_stamp;
  assign evt_pre_freq = q.pc_pre;
  assign evt_fault_freq = q.pc_fault;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_fresh_pick;
    q.pc && pick_new[0] && !q.picked[0];
  endsequence

  sequence s_run;
    q.pc && q.picked[0] && pick_new[0] && q.started[0] && !q.tripped[0];
  endsequence

  a_disabled_quiet: assert property (q.pc && !en[0] |=> !q.picked[0] && !q.started[0])
    else $error("disabled stage picked up");
  a_over_pickup: assert property (q.pc && en[0] && q.freq_q > q.thr[0] |=> q.picked[0])
    else $error("over stage missed pick-up");
  a_hold_hyst: assert property (q.pc && en[0] && q.picked[0]
    && q.freq_q > q.thr[0] - frqp_pkg::HYS |=> q.picked[0])
    else $error("stage dropped inside hysteresis");
  a_block_pickup: assert property (s_fresh_pick and blk_now |=> q.blked[0] && !q.started[0])
    else $error("blocked pick-up started");
  a_start_free: assert property (s_fresh_pick and !blk_now |=> q.started[0])
    else $error("unblocked pick-up did not start");
  a_block_release: assert property (q.pc && q.started[0] && blk_now |=> !q.started[0])
    else $error("start kept under blocking");
  a_delay_trip: assert property (s_run and !blk_now and (q.cnt[0] + 19'h00001 >= q.dly[0])
    |=> q.tripped[0])
    else $error("trip late");
  a_block_sample: assert property (!q.pc |=> $stable(q.blk_q))
    else $error("blocking sampled outside program cycle");
  a_event_select: assert property (q.evt_v |-> q.ctrl[frqp_pkg::CTRL_EVSEL_LSB
    + (q.evt_code[0] ? 0 : 1)])
    else $error("unselected event issued");
  a_event_drain: assert property (q.pend != '0 && !q.pc |=> $countones(q.pend)
    == $countones($past(q.pend)) - 1)
    else $error("pending event not drained");

endmodule : frqp_top

`default_nettype wire

/* include/frqp_pkg.sv */
package frqp_pkg;

  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int NSTG = 8;
  localparam int NOVER = 4;
  localparam int FW = 16;
  localparam int DW = 19;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TS_RES_NS = 1000000;
  localparam int MS_CYCLES = TS_RES_NS / CLK_PERIOD_NS;
  localparam int DLY_STEP_MS = 5;
  localparam int PC_MS = DLY_STEP_MS;
  localparam int PRE_MS = 20;
  localparam int PRE_DEPTH = PRE_MS / PC_MS;
  localparam int REC_DEPTH = 12;
  localparam int FREQ_STEP_MHZ = 10;
  localparam int HYS_MHZ = 20;
  localparam logic [FW-1:0] HYS = 16'(HYS_MHZ / FREQ_STEP_MHZ);
  localparam logic [DW-1:0] DLY_MAX = 19'h57E40;
  localparam logic [25:0] RATIO_SCALE = 26'h03E8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [FW-1:0] THR_OVER_RST = 16'h13EC;
  localparam logic [FW-1:0] THR_UNDER_RST = 16'h1324;
  localparam logic [DW-1:0] DLY_RST = 19'h00014;
  localparam logic [31:0] CTRL_RST = 32'h00000061;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CNT_CLR = 8'h08;
  localparam logic [7:0] REG_RATIO = 8'h0C;
  localparam logic [7:0] REG_REMAIN = 8'h10;
  localparam logic [7:0] REG_EXPECT = 8'h14;
  localparam logic [7:0] REG_COUNTS = 8'h18;
  localparam logic [7:0] REG_REC_SEL = 8'h1C;
  localparam logic [7:0] REG_REC_TIME = 8'h20;
  localparam logic [7:0] REG_REC_EVT = 8'h24;
  localparam logic [7:0] REG_REC_FREQ = 8'h28;
  localparam logic [2:0] REG_THR_PAGE = 3'h2;
  localparam logic [2:0] REG_DLY_PAGE = 3'h3;

  // ----------------------------------------------------------------------
  // Control fields and codes
  // ----------------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FORCE = 3;
  localparam int CTRL_SWBLK = 4;
  localparam int CTRL_EVSEL_LSB = 5;
  localparam int CTRL_SG_LSB = 7;
  localparam int CTRL_SEL_LSB = 10;
  localparam int THR_SGEN_LSB = 16;
  localparam int DLY_FORCE_LSB = 19;
  localparam logic [2:0] MODE_BLOCKED = 3'h2;
  localparam logic [2:0] MODE_TESTBLK = 3'h4;
  localparam logic [2:0] MODE_OFF = 3'h5;
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam logic [1:0] KIND_START = 2'h0;
  localparam logic [1:0] KIND_TRIP = 2'h1;
  localparam logic [1:0] KIND_BLOCKED = 2'h2;

endpackage : frqp_pkg
